// File: sld_defs.vh
// What this block does
// - eight-bit shift register, eight latches, one output per latch
// - rising shift-clock edge captures serial input into first stage
// - each further rising edge moves bits one stage toward serial output
// - strobe high copies every register stage into its latch
// - latches track register while strobe high, hold when it falls
// - output enable high forces driver outputs off, serial output and storage unchanged
// - output enable low: each output follows its own latch bit
// - serial data output carries shifted data for chaining
`ifndef SLD_DEFS_VH
`define SLD_DEFS_VH
`define SLD_WIDTH      8
`define SLD_FIFO_DEPTH 4
`define SLD_FIFO_AW    2
`define SLD_ZERO8      8'h00
`define SLD_OFF8       8'h00
`endif

// File: sld_fifo.v
`timescale 1ns/1ps
`default_nettype none
module sld_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_r;
    reg [AW-1:0]    rd_ptr_r;
    reg [AW:0]      count_r;
    reg             out_valid_r;
    wire            push;
    wire            pop;
    wire            load;
    // full level held at the counter's own width
    localparam [AW:0] FULL_LVL = DEPTH;
    assign in_ready  = (count_r != FULL_LVL);
    assign push      = in_valid & in_ready;
    // registered read stage refills when empty or taken
    assign load      = (count_r != {(AW+1){1'b0}}) &
                       (~out_valid_r | out_ready);
    assign pop       = load;
    assign out_valid = out_valid_r;
    always @(posedge core_clk)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            wr_ptr_r    <= {AW{1'b0}};
            rd_ptr_r    <= {AW{1'b0}};
            count_r     <= {(AW+1){1'b0}};
            out_valid_r <= 1'b0;
            out_data    <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                out_data <= mem_r[rd_ptr_r];
            end
            if (push & ~pop)
            begin
                count_r <= count_r + 1'b1;
            end
            else if (pop & ~push)
            begin
                count_r <= count_r - 1'b1;
            end
            if (load)
            begin
                out_valid_r <= 1'b1;
            end
            else if (out_ready)
            begin
                out_valid_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: sld_driver.v
`timescale 1ns/1ps
`default_nettype none
`include "sld_defs.vh"
module sld_driver (
    // clock and reset
    input  wire                   core_clk,
    input  wire                   sys_rst,
    // serial link pins from the controller
    input  wire                   shift_clk,
    input  wire                   ser_in,
    input  wire                   strobe,
    input  wire                   out_enable_n_off,
    // chain output
    output reg                    ser_out,
    // driver outputs, high means on
    output reg  [`SLD_WIDTH-1:0]  drv_out
);
    // two-flop synchronisers, first stage read only by second
    reg [3:0] meta_r;
    reg [3:0] sync_r;
    reg       clk_d_r;
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            meta_r  <= 4'h0;
            sync_r  <= 4'h0;
            clk_d_r <= 1'b0;
        end
        else
        begin
            meta_r  <= {shift_clk, ser_in, strobe, out_enable_n_off};
            sync_r  <= meta_r;
            clk_d_r <= sync_r[3];
        end
    end
    wire clk_s    = sync_r[3];
    wire data_s   = sync_r[2];
    wire strobe_s = sync_r[1];
    wire blank_s  = sync_r[0];
    // data and clock share sync delay, so setup at the pin is kept
    wire rise     = clk_s & ~clk_d_r;
    // captured bits pass the fifo so bursts are not lost
    wire                  f_ready;
    wire                  f_valid;
    wire [0:0]            f_data;
    sld_fifo #(
        .WIDTH (1),
        .DEPTH (`SLD_FIFO_DEPTH),
        .AW    (`SLD_FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (rise),
        .in_ready  (f_ready),
        .in_data   (data_s),
        .out_valid (f_valid),
        .out_ready (1'b1),
        .out_data  (f_data)
    );
    // limitation: edges beyond fifo room are dropped
    reg [`SLD_WIDTH-1:0] shreg_r;
    reg [`SLD_WIDTH-1:0] shreg_nxt;
    reg [`SLD_WIDTH-1:0] latch_r;
    reg [`SLD_WIDTH-1:0] latch_nxt;
    always @*
    begin
        shreg_nxt = shreg_r;
        if (f_valid)
        begin
            // stage 0 takes input, rest move toward ser_out
            shreg_nxt = {shreg_r[`SLD_WIDTH-2:0], f_data[0]};
        end
    end
    always @*
    begin
        latch_nxt = latch_r;
        if (strobe_s)
        begin
            latch_nxt = shreg_r;
        end
    end
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            shreg_r <= `SLD_ZERO8;
            latch_r <= `SLD_ZERO8;
            ser_out <= 1'b0;
            drv_out <= `SLD_OFF8;
        end
        else
        begin
            shreg_r <= shreg_nxt;
            latch_r <= latch_nxt;
            ser_out <= shreg_nxt[`SLD_WIDTH-1];
            // blanking leaves shreg and latch untouched
            drv_out <= blank_s ? `SLD_OFF8 : latch_nxt;
        end
    end
    wire unused_ready = f_ready;
endmodule
`default_nettype wire

// File: sld_driver_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sld_asserts (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       sys_rst,
    // pins
    input wire logic       shift_clk,
    input wire logic       strobe,
    input wire logic       out_enable_n_off,
    input wire logic       ser_out,
    input wire logic [7:0] drv_out
);
    wire oe = out_enable_n_off;
    wire tr = strobe & ~oe;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // quiet window long enough for sync and fifo to settle
    sequence s_q; (tr && $stable(shift_clk))[*8]; endsequence
    property p_rst; disable iff (1'b0) sys_rst |=> drv_out == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_off; oe[*5] |-> drv_out == 8'h00; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_oe; $rose(oe) |-> ##[0:5] (drv_out == 8'h00 || !oe); endproperty
    a_oe: assert property (p_oe) else $error("blank");
    property p_hold; (!strobe && !oe)[*6] |=> $stable(drv_out); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_trk; s_q |-> drv_out[7] == ser_out; endproperty
    a_trk: assert property (p_trk) else $error("track");
    property p_still; s_q |-> $stable(drv_out); endproperty
    a_still: assert property (p_still) else $error("still");
    property p_quiet; $stable(shift_clk)[*8] |=> $stable(ser_out); endproperty
    a_quiet: assert property (p_quiet) else $error("quiet");
    property p_lat; $rose(shift_clk) |=> $stable(ser_out)[*2]; endproperty
    a_lat: assert property (p_lat) else $error("early");
endmodule
bind sld_driver sld_asserts sld_asserts_i (.core_clk, .sys_rst, .shift_clk,
    .strobe, .out_enable_n_off, .ser_out, .drv_out);
`default_nettype wire

// File: sld_host.sv
`timescale 1ns/1ps
`default_nettype none
module sld_host (
    input wire logic  core_clk,
    output var logic  shift_clk = 1'b0,
    output var logic  ser_in = 1'b0,
    output var logic  strobe = 1'b0,
    output var logic  out_enable_n_off = 1'b0
);
    // msb first, 160 ns clock, data set half a period before the edge
    task automatic send(input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
        begin
            ser_in <= d[i];
            repeat (8) @(posedge core_clk);
            shift_clk <= 1'b1;
            repeat (8) @(posedge core_clk);
            shift_clk <= 1'b0;
        end
        ser_in <= ~ser_in;
    endtask
    task automatic ctl(input logic s, input logic o);
        strobe <= s;
        out_enable_n_off <= o;
        repeat (12) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: sld_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sld_driver_bench;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    wire sclk, sdin, stb, oe, ser_out;
    wire [7:0] drv_out;
    int miscompares = 0;
    int n_tests = 0;
    initial forever #5 core_clk = ~core_clk;
    sld_host sld_host_i (.core_clk, .shift_clk(sclk), .ser_in(sdin),
        .strobe(stb), .out_enable_n_off(oe));
    sld_driver sld_driver_i (.core_clk, .sys_rst, .shift_clk(sclk),
        .ser_in(sdin), .strobe(stb), .out_enable_n_off(oe), .ser_out,
        .drv_out);
    task automatic chk(input logic [8:0] e);
        n_tests++;
        miscompares += ({ser_out, drv_out} !== e);
        if ({ser_out, drv_out} !== e)
            $display("wrong value outs expected %h seen %h", e,
                {ser_out, drv_out});
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic t_latch;
        sld_host_i.send(8'ha5);
        sld_host_i.ctl(1'b1, 1'b0);
        sld_host_i.ctl(1'b0, 1'b0);
        chk(9'h1a5);
    endtask
    // blanking must leave both stores alone
    task automatic t_blank;
        sld_host_i.ctl(1'b0, 1'b1);
        chk(9'h100);
        sld_host_i.send(8'h3c);
        sld_host_i.ctl(1'b0, 1'b0);
        chk(9'h0a5);
        sld_host_i.ctl(1'b1, 1'b0);
        chk(9'h03c);
    endtask
    task automatic t_bypass;
        sld_host_i.ctl(1'b1, 1'b1);
        sld_host_i.send(8'h81);
        chk(9'h100);
        sld_host_i.ctl(1'b1, 1'b0);
        chk(9'h181);
    endtask
    // mid-run reset clears every store
    task automatic t_reset;
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk(9'h000);
    endtask
    initial
    begin
        repeat (3000) @(posedge core_clk);
        miscompares++;
        end_of_test();
    end
    initial
    begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_latch();
        t_blank();
        t_bypass();
        t_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
